//--- src/logic_string_decode_pkg.sv
// constants and types for the logic-group and string-group decode block
// assumes a core clock of 50 MHz; all inputs come from core logic on that clock
package logic_string_decode_pkg;

  // execution clocks
  localparam logic [7:0] CLK_REG           = 8'h02;
  localparam logic [7:0] CLK_REG_TO_MEM    = 8'h07;
  localparam logic [7:0] CLK_MEM_TO_REG    = 8'h06;
  localparam logic [7:0] CLK_IMM_MEM       = 8'h07;
  localparam logic [7:0] CLK_TEST_MEM      = 8'h05;
  localparam logic [7:0] CLK_INVERT_MEM    = 8'h06;
  localparam logic [7:0] CLK_CMP_STR       = 8'h0A;
  localparam logic [7:0] CLK_PIN_REAL      = 8'h0F;
  localparam logic [7:0] CLK_PIN_V86       = 8'h1D;
  localparam logic [7:0] CLK_PIN_PRIV      = 8'h09;
  localparam logic [7:0] CLK_PIN_NOPRIV    = 8'h1D;
  localparam logic [7:0] CLK_POUT_REAL     = 8'h0E;
  localparam logic [7:0] CLK_POUT_V86      = 8'h1C;
  localparam logic [7:0] CLK_POUT_PRIV     = 8'h08;
  localparam logic [7:0] CLK_POUT_NOPRIV   = 8'h1C;
  localparam logic [7:0] CLK_LOAD_STR      = 8'h05;
  localparam logic [7:0] CLK_MOVE_STR      = 8'h08;
  localparam logic [7:0] CLK_SCAN_STR      = 8'h08;
  localparam logic [7:0] CLK_STORE_STR     = 8'h05;
  localparam logic [7:0] CLK_TABLE         = 8'h05;
  localparam logic [7:0] CLK_REP_BASE      = 8'h05;
  localparam logic [7:0] CLK_REP_CMP_ITER  = 8'h09;

  // opcode patterns
  localparam logic [7:0] OPC_AND_RM    = 8'b0010_00??;
  localparam logic [7:0] OPC_OR_RM     = 8'b0000_10??;
  localparam logic [7:0] OPC_XOR_RM    = 8'b0011_00??;
  localparam logic [7:0] OPC_AND_ACC   = 8'b0010_010?;
  localparam logic [7:0] OPC_OR_ACC    = 8'b0000_110?;
  localparam logic [7:0] OPC_XOR_ACC   = 8'b0011_010?;
  localparam logic [7:0] OPC_GRP_IMM   = 8'b1000_00??;
  localparam logic [7:0] OPC_TEST_RM   = 8'b1000_010?;
  localparam logic [7:0] OPC_GRP_UNARY = 8'b1111_011?;
  localparam logic [7:0] OPC_TEST_ACC  = 8'b1010_100?;
  localparam logic [7:0] OPC_CMP_STR   = 8'b1010_011?;
  localparam logic [7:0] OPC_PIN       = 8'b0110_110?;
  localparam logic [7:0] OPC_POUT      = 8'b0110_111?;
  localparam logic [7:0] OPC_LOAD_STR  = 8'b1010_110?;
  localparam logic [7:0] OPC_MOVE_STR  = 8'b1010_010?;
  localparam logic [7:0] OPC_SCAN_STR  = 8'b1010_111?;
  localparam logic [7:0] OPC_STORE_STR = 8'b1010_101?;
  localparam logic [7:0] OPC_TABLE     = 8'hD7;
  localparam logic [7:0] OPC_REP_EQ    = 8'hF3;

  // opcode bit positions and ModR/M fields
  localparam int         DIR_BIT   = 1;
  localparam int         WIDTH_BIT = 0;
  localparam logic [1:0] MOD_REG   = 2'h3;
  localparam logic [2:0] SEL_AND   = 3'h4;
  localparam logic [2:0] SEL_OR    = 3'h1;
  localparam logic [2:0] SEL_XOR   = 3'h6;
  localparam logic [2:0] SEL_TEST  = 3'h0;
  localparam logic [2:0] SEL_NOT   = 3'h2;

  typedef enum logic [1:0] {MODE_REAL = 2'b00, MODE_V86 = 2'b01, MODE_PROT = 2'b10} mode_t;
  typedef enum logic [1:0] {W_BYTE = 2'b00, W_WORD = 2'b01, W_DWORD = 2'b10} width_t;
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000, OP_AND = 4'b0001, OP_OR = 4'b0010, OP_XOR = 4'b0011,
    OP_TEST = 4'b0100, OP_NOT = 4'b0101, OP_CMP_STR = 4'b0110, OP_PIN = 4'b0111,
    OP_POUT = 4'b1000, OP_LOAD_STR = 4'b1001, OP_MOVE_STR = 4'b1010,
    OP_SCAN_STR = 4'b1011, OP_STORE_STR = 4'b1100, OP_TABLE = 4'b1101
  } op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_REP_BASE = 2'b10, ST_REP_ITER = 2'b11
  } state_t;

  typedef struct packed {
    op_t        op;
    width_t     width;
    logic [7:0] clocks;
    logic       mem;
    logic       writes;
    logic       legal;
  } dec_t;

  typedef struct packed {
    state_t      state;
    logic [7:0]  cnt;
    op_t         op;
    width_t      width;
    logic [7:0]  clocks;
    logic        mem;
    logic        writes;
    logic        busy;
    logic        done;
    logic        illegal;
    logic        rep;
    logic        iter_done;
    logic        addr32;
    logic [31:0] count;
  } st_t;

  localparam st_t ST_RESET = '{state: ST_IDLE, op: OP_NONE, width: W_BYTE, default: '0};

endpackage

//--- src/logic_string_decode.sv
// decode and execution-clock sequencer for the logic and string groups
// assumes opcode, ModR/M, mode and count come from core logic on i_mclk
// Functional notes
// - and reg-to-mem 7, mem-to-reg 6
// - group immediate: reg field picks operation
// - accumulator immediate forms take 2 clocks
// - test reg/mem: flags only, 2/5
// - F6/F7 field 000 is test immediate
// - test accumulator short form 2 clocks
// - or reg-to-mem 7, mem-to-reg 6
// - xor reg-to-mem 7, mem-to-reg 6
// - or/xor register forms take 2 clocks
// - F6/F7 field 010 inverts, 2/6
// - compare string takes 10 clocks
// - port input string 15/29/9/29
// - port output string 14/28/8/28
// - load string takes 5 clocks
// - move string takes 8 clocks
// - scan string takes 8 clocks
// - store string takes 5 clocks
// - table translate takes 5 clocks
// - repeats count with 16/32-bit count register
// - repeat-while-equal compare costs 5+9n
// - and register form takes 2 clocks
`timescale 1ns/1ps

module logic_string_decode
  import logic_string_decode_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // instruction bytes
  input  wire logic        i_start,
  input  wire logic        i_prefix_valid,
  input  wire logic [7:0]  i_prefix,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [7:0]  i_modrm,
  // machine context
  input  wire logic [1:0]  i_mode,
  input  wire logic        i_io_priv_ok,
  input  wire logic        i_opsize32,
  input  wire logic        i_addr32,
  input  wire logic [31:0] i_count,
  input  wire logic        i_elem_match,
  // status
  output logic             o_busy,
  output logic             o_done,
  output logic             o_illegal,
  output logic             o_iter_done,
  // decoded instruction
  output logic [3:0]       o_op,
  output logic [1:0]       o_width,
  output logic             o_mem,
  output logic             o_writes,
  output logic             o_repeat,
  output logic [7:0]       o_clocks,
  output logic [31:0]      o_count
);

  st_t  st;
  st_t  next_st;
  dec_t dec;
  logic take;

  function automatic logic count_zero(input logic [31:0] cnt, input logic wide);
    count_zero = wide ? (cnt == 32'h0000_0000) : (cnt[15:0] == 16'h0000);
  endfunction

  // only the low half moves for a 16-bit count, the upper half is kept
  function automatic logic [31:0] count_dec(input logic [31:0] cnt, input logic wide);
    count_dec = wide ? (cnt - 32'h0000_0001) : {cnt[31:16], cnt[15:0] - 16'h0001};
  endfunction

  function automatic logic [7:0] rm_clocks(input logic [7:0] opc, input logic mem);
    if (!mem)
      rm_clocks = CLK_REG;
    else if (opc[DIR_BIT])
      rm_clocks = CLK_MEM_TO_REG;
    else
      rm_clocks = CLK_REG_TO_MEM;
  endfunction

  function automatic dec_t decode(input logic [7:0] opc, input logic [7:0] modrm,
                                  input mode_t mode, input logic io_ok, input logic op32);
    dec_t d;
    logic mem;
    mem      = modrm[7:6] != MOD_REG;
    d.op     = OP_NONE;
    d.clocks = 8'h00;
    d.mem    = 1'b0;
    d.writes = 1'b1;
    d.legal  = 1'b1;
    d.width  = !opc[WIDTH_BIT] ? W_BYTE : (op32 ? W_DWORD : W_WORD);
    casez (opc)
      OPC_AND_RM, OPC_OR_RM, OPC_XOR_RM:
      begin
        d.op     = (opc[5:4] == 2'b10) ? OP_AND : ((opc[5:4] == 2'b00) ? OP_OR : OP_XOR);
        d.mem    = mem;
        d.clocks = rm_clocks(opc, mem);
      end
      OPC_AND_ACC, OPC_OR_ACC, OPC_XOR_ACC:
      begin
        d.op     = (opc[5:4] == 2'b10) ? OP_AND : ((opc[5:4] == 2'b00) ? OP_OR : OP_XOR);
        d.clocks = CLK_REG;
      end
      OPC_GRP_IMM:
      begin
        d.mem    = mem;
        d.clocks = mem ? CLK_IMM_MEM : CLK_REG;
        case (modrm[5:3])
          SEL_AND: d.op = OP_AND;
          SEL_OR:  d.op = OP_OR;
          SEL_XOR: d.op = OP_XOR;
          default: d.legal = 1'b0;
        endcase
      end
      OPC_TEST_RM:
      begin
        d.op     = OP_TEST;
        d.mem    = mem;
        d.writes = 1'b0;
        d.clocks = mem ? CLK_TEST_MEM : CLK_REG;
      end
      OPC_GRP_UNARY:
      begin
        d.mem = mem;
        case (modrm[5:3])
          SEL_TEST:
          begin
            d.op     = OP_TEST;
            d.writes = 1'b0;
            d.clocks = mem ? CLK_TEST_MEM : CLK_REG;
          end
          SEL_NOT:
          begin
            d.op     = OP_NOT;
            d.clocks = mem ? CLK_INVERT_MEM : CLK_REG;
          end
          default: d.legal = 1'b0;
        endcase
      end
      OPC_TEST_ACC:
      begin
        d.op     = OP_TEST;
        d.writes = 1'b0;
        d.clocks = CLK_REG;
      end
      OPC_CMP_STR:
      begin
        d.op     = OP_CMP_STR;
        d.writes = 1'b0;
        d.clocks = CLK_CMP_STR;
      end
      OPC_PIN:
      begin
        d.op = OP_PIN;
        case (mode)
          MODE_REAL: d.clocks = CLK_PIN_REAL;
          MODE_V86:  d.clocks = CLK_PIN_V86;
          default:   d.clocks = io_ok ? CLK_PIN_PRIV : CLK_PIN_NOPRIV;
        endcase
      end
      OPC_POUT:
      begin
        d.op = OP_POUT;
        case (mode)
          MODE_REAL: d.clocks = CLK_POUT_REAL;
          MODE_V86:  d.clocks = CLK_POUT_V86;
          default:   d.clocks = io_ok ? CLK_POUT_PRIV : CLK_POUT_NOPRIV;
        endcase
      end
      OPC_LOAD_STR:
      begin
        d.op     = OP_LOAD_STR;
        d.clocks = CLK_LOAD_STR;
      end
      OPC_MOVE_STR:
      begin
        d.op     = OP_MOVE_STR;
        d.clocks = CLK_MOVE_STR;
      end
      OPC_SCAN_STR:
      begin
        d.op     = OP_SCAN_STR;
        d.writes = 1'b0;
        d.clocks = CLK_SCAN_STR;
      end
      OPC_STORE_STR:
      begin
        d.op     = OP_STORE_STR;
        d.clocks = CLK_STORE_STR;
      end
      OPC_TABLE:
      begin
        d.op     = OP_TABLE;
        d.width  = W_BYTE;
        d.clocks = CLK_TABLE;
      end
      default: d.legal = 1'b0;
    endcase
    decode = d;
  endfunction

  assign dec  = decode(i_opcode, i_modrm, mode_t'(i_mode), i_io_priv_ok, i_opsize32);
  assign take = (st.state == ST_IDLE) && i_start;

  always_comb
  begin
    next_st           = st;
    next_st.done      = 1'b0;
    next_st.iter_done = 1'b0;
    case (st.state)
      ST_IDLE:
      begin
        if (i_start)
        begin
          next_st.illegal = !dec.legal;
          next_st.rep     = 1'b0;
          if (!dec.legal)
          begin
            // unknown encodings answer at once so the core never hangs
            next_st.done = 1'b1;
            next_st.op   = OP_NONE;
          end
          else
          begin
            next_st.op     = dec.op;
            next_st.width  = dec.width;
            next_st.mem    = dec.mem;
            next_st.writes = dec.writes;
            next_st.count  = i_count;
            next_st.addr32 = i_addr32;
            if (i_prefix_valid && (i_prefix == OPC_REP_EQ) && (dec.op == OP_CMP_STR))
            begin
              next_st.rep    = 1'b1;
              next_st.state  = ST_REP_BASE;
              next_st.cnt    = CLK_REP_BASE;
              next_st.clocks = CLK_REP_BASE;
            end
            else
            begin
              next_st.state  = ST_RUN;
              next_st.cnt    = dec.clocks;
              next_st.clocks = dec.clocks;
            end
          end
        end
      end
      ST_RUN:
      begin
        next_st.cnt = st.cnt - 8'h01;
        if (st.cnt == 8'h01)
        begin
          next_st.state = ST_IDLE;
          next_st.done  = 1'b1;
        end
      end
      ST_REP_BASE:
      begin
        next_st.cnt = st.cnt - 8'h01;
        if (st.cnt == 8'h01)
        begin
          if (count_zero(st.count, st.addr32))
          begin
            next_st.state = ST_IDLE;
            next_st.done  = 1'b1;
          end
          else
          begin
            next_st.state = ST_REP_ITER;
            next_st.cnt   = CLK_REP_CMP_ITER;
          end
        end
      end
      ST_REP_ITER:
      begin
        next_st.cnt = st.cnt - 8'h01;
        if (st.cnt == 8'h01)
        begin
          next_st.count     = count_dec(st.count, st.addr32);
          next_st.iter_done = 1'b1;
          next_st.cnt       = CLK_REP_CMP_ITER;
          if (count_zero(next_st.count, st.addr32) || !i_elem_match)
          begin
            next_st.state = ST_IDLE;
            next_st.done  = 1'b1;
          end
        end
      end
      default: next_st = ST_RESET;
    endcase
    next_st.busy = next_st.state != ST_IDLE;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  assign o_busy      = st.busy;
  assign o_done      = st.done;
  assign o_illegal   = st.illegal;
  assign o_iter_done = st.iter_done;
  assign o_op        = st.op;
  assign o_width     = st.width;
  assign o_mem       = st.mem;
  assign o_writes    = st.writes;
  assign o_repeat    = st.rep;
  assign o_clocks    = st.clocks;
  assign o_count     = st.count;

  // helper: busy cycles of the current instruction
  logic [7:0] busy_len;
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      busy_len <= 8'h00;
    else
      busy_len <= o_busy ? busy_len + 8'h01 : 8'h00;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  sequence s_take;
    take;
  endsequence
  sequence s_iter_last;
    (st.state == ST_REP_ITER) && (st.cnt == 8'h01);
  endsequence

  AST_AND_TO_MEM: assert property (s_take ##0 (i_opcode == 8'h20) && (i_modrm[7:6] != 2'h3)
    |=> o_busy && (o_clocks == 8'h07)) else $error("and to memory not 7 clocks");
  AST_GRP_OR: assert property (s_take ##0 (i_opcode == 8'h80) && (i_modrm == 8'hC9)
    |=> (o_op == OP_OR) && (o_clocks == 8'h02)) else $error("group or misdecoded");
  AST_ACC_XOR: assert property (s_take ##0 (i_opcode == 8'h34)
    |=> (o_op == OP_XOR) && (o_clocks == 8'h02)) else $error("xor acc not 2");
  AST_TEST_NOWRITE: assert property (s_take ##0 (i_opcode == 8'h85) && (i_modrm[7:6] != 2'h3)
    |=> !o_writes && (o_clocks == 8'h05)) else $error("test writes or wrong count");
  AST_INVERT_MEM: assert property (s_take ##0 (i_opcode == 8'hF7) && (i_modrm == 8'h10)
    |=> (o_op == OP_NOT) && (o_clocks == 8'h06)) else $error("invert mem not 6");
  AST_INS_PROT: assert property (s_take ##0 (i_opcode == 8'h6C) && (i_mode == 2'b10)
    |=> o_clocks == (i_io_priv_ok ? 8'h09 : 8'h1D)) else $error("port input count");
  AST_BUSY_LEN: assert property (o_done && !o_illegal && !o_repeat
    |-> busy_len == o_clocks) else $error("busy length differs from clocks");
  AST_WIDTH: assert property (s_take ##0 (i_opcode == 8'hAB) && i_opsize32
    |=> o_width == W_DWORD) else $error("width bit misread");
  AST_REP_DEC: assert property (o_iter_done
    |-> o_count[15:0] == $past(o_count[15:0]) - 16'h0001) else $error("count not decremented");
  AST_REP_MISMATCH: assert property (s_iter_last ##0 !i_elem_match
    |=> o_done && !o_busy && o_iter_done) else $error("mismatch did not stop");
  AST_REP_ITER_LEN: assert property (o_iter_done && o_busy
    |=> (!o_iter_done)[*8] ##1 o_iter_done) else $error("iteration not 9 clocks");
  AST_REP_ZERO: assert property (s_take ##0 i_prefix_valid && (i_prefix == 8'hF3)
    && (i_opcode == 8'hA6) && (i_count[15:0] == 16'h0000)
    && (!i_addr32 || (i_count[31:16] == 16'h0000))
    |=> o_busy[*5] ##1 (o_done && !o_iter_done)) else $error("zero count repeat");

endmodule // logic_string_decode

//--- dv/logic_string_decode_tb.sv
// self-checking bench for the logic and string decode sequencer
// assumes the design package is compiled first; the bench drives every design input
`timescale 1ns/1ps

module testbench
  import logic_string_decode_pkg::*;
;
  // clock and reset
  logic        i_mclk;
  logic        i_arst_n;
  // stimulus
  logic        i_start;
  logic        i_prefix_valid;
  logic [7:0]  i_prefix;
  logic [7:0]  i_opcode;
  logic [7:0]  i_modrm;
  logic [1:0]  i_mode;
  logic        i_io_priv_ok;
  logic        i_opsize32;
  logic        i_addr32;
  logic [31:0] i_count;
  logic        i_elem_match;
  // observed
  logic        o_busy;
  logic        o_done;
  logic        o_illegal;
  logic        o_iter_done;
  logic [3:0]  o_op;
  logic [1:0]  o_width;
  logic        o_mem;
  logic        o_writes;
  logic        o_repeat;
  logic [7:0]  o_clocks;
  logic [31:0] o_count;
  int          failures;
  int          num_checks;
  int          cycles;
  int          n;
  int          it;

  logic_string_decode DUT (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_start(i_start),
    .i_prefix_valid(i_prefix_valid), .i_prefix(i_prefix), .i_opcode(i_opcode),
    .i_modrm(i_modrm), .i_mode(i_mode), .i_io_priv_ok(i_io_priv_ok),
    .i_opsize32(i_opsize32), .i_addr32(i_addr32), .i_count(i_count),
    .i_elem_match(i_elem_match), .o_busy(o_busy), .o_done(o_done),
    .o_illegal(o_illegal), .o_iter_done(o_iter_done), .o_op(o_op),
    .o_width(o_width), .o_mem(o_mem), .o_writes(o_writes), .o_repeat(o_repeat),
    .o_clocks(o_clocks), .o_count(o_count)
  );

  always #10 i_mclk = ~i_mclk;

  task automatic close_out;
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a hang would leave the run open forever, so the cycle ceiling ends it
  always @(posedge i_mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask

  // one take, then busy cycles and iteration pulses are counted until done
  task automatic go(input logic pv, input logic [7:0] pf, input logic [7:0] opc,
                    input logic [7:0] mr, input logic [1:0] md, input logic pr,
                    input logic o32, input logic a32, input logic [31:0] cnt);
    int k;
    @(posedge i_mclk);
    i_start        <= 1'b1;
    i_prefix_valid <= pv;
    i_prefix       <= pf;
    i_opcode       <= opc;
    i_modrm        <= mr;
    i_mode         <= md;
    i_io_priv_ok   <= pr;
    i_opsize32     <= o32;
    i_addr32       <= a32;
    i_count        <= cnt;
    @(posedge i_mclk);
    i_start <= 1'b0;
    n = 0;
    it = 0;
    for (k = 0; k < 400; k++)
    begin
      #1;
      if (o_iter_done === 1'b1)
        it++;
      if (o_done === 1'b1)
        break;
      if (o_busy === 1'b1)
        n++;
      @(posedge i_mclk);
    end
    chk("done", 1'b1, o_done);
  endtask

  task automatic x(input logic [7:0] opc, input logic [7:0] mr, input logic [1:0] md,
                   input logic pr, input logic [7:0] clk, input logic [3:0] op);
    go(1'b0, 8'h00, opc, mr, md, pr, 1'b1, 1'b1, 32'h0000_0000);
    chk("busy length", {24'h00_0000, clk}, n);
    chk("clocks", {24'h00_0000, clk}, {24'h00_0000, o_clocks});
    chk("op", {28'h000_0000, op}, {28'h000_0000, o_op});
  endtask

  task automatic t_two_operand;
    x(8'h20, 8'h00, 2'h0, 1'b1, 8'h07, 4'h1);
    chk("mem", 1'b1, o_mem);
    x(8'h22, 8'h00, 2'h2, 1'b1, 8'h06, 4'h1);
    x(8'h20, 8'hC0, 2'h0, 1'b1, 8'h02, 4'h1);
    x(8'h08, 8'h00, 2'h0, 1'b1, 8'h07, 4'h2);
    x(8'h0A, 8'h00, 2'h0, 1'b1, 8'h06, 4'h2);
    x(8'h0B, 8'hC0, 2'h0, 1'b1, 8'h02, 4'h2);
    x(8'h30, 8'h00, 2'h0, 1'b1, 8'h07, 4'h3);
    x(8'h33, 8'h00, 2'h0, 1'b1, 8'h06, 4'h3);
    x(8'h32, 8'hC0, 2'h2, 1'b1, 8'h02, 4'h3);
  endtask

  task automatic t_group_imm;
    logic [2:0] sel [3] = '{3'h4, 3'h1, 3'h6};
    for (int i = 0; i < 3; i++)
    begin
      x(8'h80, {2'h3, sel[i], 3'h1}, 2'h0, 1'b1, 8'h02, 4'(i + 1));
      x(8'h81, {2'h0, sel[i], 3'h2}, 2'h2, 1'b1, 8'h07, 4'(i + 1));
      x(8'h83, {2'h1, sel[i], 3'h0}, 2'h0, 1'b1, 8'h07, 4'(i + 1));
    end
    go(1'b0, 8'h00, 8'h80, 8'hC0, 2'h0, 1'b1, 1'b1, 1'b1, 32'h0000_0000);
    chk("illegal", 1'b1, o_illegal);
  endtask

  task automatic t_flags_and_unary;
    x(8'h24, 8'h00, 2'h0, 1'b1, 8'h02, 4'h1);
    x(8'h0D, 8'h00, 2'h2, 1'b1, 8'h02, 4'h2);
    x(8'h34, 8'h00, 2'h0, 1'b1, 8'h02, 4'h3);
    x(8'hA8, 8'h00, 2'h0, 1'b1, 8'h02, 4'h4);
    chk("writes", 1'b0, o_writes);
    x(8'h84, 8'hC0, 2'h0, 1'b1, 8'h02, 4'h4);
    x(8'h85, 8'h00, 2'h2, 1'b1, 8'h05, 4'h4);
    chk("writes", 1'b0, o_writes);
    x(8'hF6, 8'hC0, 2'h0, 1'b1, 8'h02, 4'h4);
    x(8'hF7, 8'h00, 2'h0, 1'b1, 8'h05, 4'h4);
    x(8'hF6, 8'hD0, 2'h0, 1'b1, 8'h02, 4'h5);
    x(8'hF7, 8'h10, 2'h2, 1'b1, 8'h06, 4'h5);
    chk("writes", 1'b1, o_writes);
  endtask

  task automatic t_strings;
    x(8'hA6, 8'h00, 2'h0, 1'b1, 8'h0A, 4'h6);
    x(8'hA7, 8'h00, 2'h2, 1'b0, 8'h0A, 4'h6);
    x(8'hAC, 8'h00, 2'h0, 1'b1, 8'h05, 4'h9);
    x(8'hA5, 8'h00, 2'h1, 1'b1, 8'h08, 4'hA);
    x(8'hAF, 8'h00, 2'h2, 1'b1, 8'h08, 4'hB);
    chk("writes", 1'b0, o_writes);
    x(8'hAA, 8'h00, 2'h0, 1'b1, 8'h05, 4'hC);
    x(8'hD7, 8'h00, 2'h0, 1'b1, 8'h05, 4'hD);
  endtask

  task automatic t_ports;
    x(8'h6C, 8'h00, 2'h0, 1'b0, 8'h0F, 4'h7);
    x(8'h6D, 8'h00, 2'h1, 1'b1, 8'h1D, 4'h7);
    x(8'h6C, 8'h00, 2'h2, 1'b1, 8'h09, 4'h7);
    x(8'h6D, 8'h00, 2'h2, 1'b0, 8'h1D, 4'h7);
    x(8'h6E, 8'h00, 2'h0, 1'b0, 8'h0E, 4'h8);
    x(8'h6F, 8'h00, 2'h1, 1'b1, 8'h1C, 4'h8);
    x(8'h6E, 8'h00, 2'h2, 1'b1, 8'h08, 4'h8);
    x(8'h6F, 8'h00, 2'h2, 1'b0, 8'h1C, 4'h8);
  endtask

  task automatic t_width;
    go(1'b0, 8'h00, 8'h20, 8'hC0, 2'h0, 1'b1, 1'b1, 1'b1, 32'h0000_0000);
    chk("width", 2'h0, o_width);
    go(1'b0, 8'h00, 8'h21, 8'hC0, 2'h0, 1'b1, 1'b0, 1'b1, 32'h0000_0000);
    chk("width", 2'h1, o_width);
    go(1'b0, 8'h00, 8'hAB, 8'h00, 2'h2, 1'b1, 1'b1, 1'b1, 32'h0000_0000);
    chk("width", 2'h2, o_width);
  endtask

  task automatic t_repeat;
    @(posedge i_mclk);
    i_elem_match <= 1'b1;
    go(1'b1, 8'hF3, 8'hA6, 8'h00, 2'h0, 1'b1, 1'b1, 1'b1, 32'h0000_0002);
    chk("repeat busy", 32'd23, n);
    chk("repeat", 32'h1, o_repeat);
    chk("repeat base", 8'h05, o_clocks);
    chk("iterations", 32'd2, it);
    chk("count", 32'h0000_0000, o_count);
    go(1'b1, 8'hF3, 8'hA7, 8'h00, 2'h0, 1'b1, 1'b1, 1'b0, 32'h0001_0002);
    chk("repeat busy", 32'd23, n);
    chk("count", 32'h0001_0000, o_count);
    go(1'b1, 8'hF3, 8'hA6, 8'h00, 2'h2, 1'b1, 1'b1, 1'b0, 32'hABCD_0000);
    chk("repeat busy", 32'd5, n);
    @(posedge i_mclk);
    i_elem_match <= 1'b0;
    go(1'b1, 8'hF3, 8'hA6, 8'h00, 2'h0, 1'b1, 1'b1, 1'b1, 32'h0000_0005);
    chk("repeat busy", 32'd14, n);
    chk("count", 32'h0000_0004, o_count);
  endtask

  // start stays high: ignored while busy, taken on the edge that sees done
  task automatic t_back_to_back;
    @(posedge i_mclk);
    i_start  <= 1'b1;
    i_opcode <= 8'h20;
    i_modrm  <= 8'h00;
    i_prefix_valid <= 1'b0;
    @(posedge i_mclk);
    i_opcode <= 8'h0C;
    repeat (7) @(posedge i_mclk);
    #1;
    chk("done", 1'b1, o_done);
    chk("op", 4'h1, o_op);
    @(posedge i_mclk);
    i_start <= 1'b0;
    #1;
    chk("busy", 1'b1, o_busy);
    chk("op", 4'h2, o_op);
    repeat (2) @(posedge i_mclk);
    #1;
    chk("done", 1'b1, o_done);
  endtask

  initial
  begin
    i_mclk = 1'b0;
    i_arst_n = 1'b0;
    i_start = 1'b0;
    i_prefix_valid = 1'b0;
    i_prefix = 8'h00;
    i_opcode = 8'h00;
    i_modrm = 8'h00;
    i_mode = 2'h0;
    i_io_priv_ok = 1'b0;
    i_opsize32 = 1'b0;
    i_addr32 = 1'b0;
    i_count = 32'h0000_0000;
    i_elem_match = 1'b0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    repeat (16) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    t_two_operand();
    t_group_imm();
    t_flags_and_unary();
    t_strings();
    t_ports();
    t_width();
    t_repeat();
    t_back_to_back();
    close_out();
  end
endmodule // testbench
